// >>> src/inj_seq_pkg.sv
// Constants, register map and state type for the injector sequencer
package inj_seq_pkg;
  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BOOST_DUR = 8'h04;
  localparam logic [7:0] OFS_PEAK_DUR = 8'h08;
  localparam logic [7:0] OFS_RETURN_DUR = 8'h0C;
  localparam logic [7:0] OFS_PEAK_CUR = 8'h10;
  localparam logic [7:0] OFS_HOLD_CUR = 8'h14;
  localparam logic [7:0] OFS_IDLE_V = 8'h18;
  localparam logic [7:0] OFS_INJECT_V = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  // Control bits
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  // Status field positions
  localparam int ST_OPEN_LSB = 0;
  localparam int ST_SHORT_BIT = 3;
  localparam int ST_BOOST_DRV_BIT = 4;
  localparam int ST_BATT_DRV_BIT = 5;
  localparam int ST_STATE_LSB = 6;
  localparam int ST_CHAN_LSB = 9;
  localparam int ST_CHARGE_BIT = 11;
  localparam int ST_EXT_HV_BIT = 12;
  // ---------------------------------------------------------------
  // Analog scaling and thresholds
  // ---------------------------------------------------------------
  localparam int CUR_LSB_MA = 250;
  localparam int VOLT_LSB_MV = 1000;
  localparam int OPEN_LOAD_MA = 2000;
  localparam int SHORT_MA = 30000;
  localparam int EXT_HV_MV = 6000;
  localparam logic [7:0] OPEN_LOAD_CODE = 8'(OPEN_LOAD_MA / CUR_LSB_MA);
  localparam logic [7:0] SHORT_CODE = 8'(SHORT_MA / CUR_LSB_MA);
  localparam logic [7:0] EXT_HV_CODE = 8'(EXT_HV_MV / VOLT_LSB_MV);
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int CHOP_DELAY_NS = 50000;
  localparam int CHOP_CYC =
    (CHOP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CHOP_W = 10;
  // ---------------------------------------------------------------
  // Sequencer phases, Gray along the injection path
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_IDLE = 3'h0,
    PH_BOOST = 3'h1,
    PH_PEAK = 3'h3,
    PH_HOLD = 3'h2,
    PH_RETURN = 3'h6
  } phase_t;
endpackage

// >>> src/injector_current_profile_sequencer.sv
// Three-channel solenoid injector current profile sequencer
// How it works
// RULE1: boost setpoint idle versus inject selected
// RULE2: lower inject setpoint limits charge, resumes after
// RULE3: external supply above 6V stops boost
// RULE4: only one channel injects at once
// RULE5: high voltage only for first peak
// RULE6: boost ends on timer or peak current
// RULE7: peak target through peak phase duration
// RULE8: chop restarts 50us after current drops
// RULE9: hold target on battery after peak
// RULE10: energy return phase after command ends
// RULE11: operator programs nonzero return, about 0.2ms
// RULE12: shorts latch, stop all until cleared
// RULE13: terminal short to supply raises short
// RULE14: ground short gives boost or battery fault
// RULE15: under 2A in boost ends pulse
// RULE16: open load updated per pulse at boost end
// RULE17: low side ground short retested each pulse; no low side short check exists, only high_terminal_gnd_short is monitored
// RULE18: phase counts loaded at start, independent
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
module injector_current_profile_sequencer
  import inj_seq_pkg::*;
#(
  parameter int TW = 16,
  parameter int NCH = 3
)(
  input wire logic clock,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic [NCH-1:0] inject_cmd,
  input wire logic [7:0] cur_sense,
  input wire logic [7:0] hv_sense,
  input wire logic [7:0] ext_hv_sense,
  input wire logic overcurrent_alarm,
  input wire logic high_terminal_gnd_short,
  output logic [NCH-1:0] channel_select,
  output logic hv_drive,
  output logic battery_drive,
  output logic energy_return,
  output logic boost_charge_en,
  output logic critical_fault,
  output logic [NCH-1:0] open_load_fault
);
  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [7:0] cur_m, cur_q, hv_m, hv_q, ext_m, ext_q;
  logic ovc_m, ovc_q, gnd_m, gnd_q;
  always_ff @(posedge clock)
  begin
    cur_m <= cur_sense;
    cur_q <= cur_m;
    hv_m <= hv_sense;
    hv_q <= hv_m;
    ext_m <= ext_hv_sense;
    ext_q <= ext_m;
    ovc_m <= overcurrent_alarm;
    ovc_q <= ovc_m;
    gnd_m <= high_terminal_gnd_short;
    gnd_q <= gnd_m;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic enable_q;
  logic [TW-1:0] boost_phase_duration, peak_phase_duration;
  logic [TW-1:0] energy_return_duration;
  logic [7:0] peak_current_target, hold_current_target;
  logic [7:0] idle_voltage_setpoint, inject_voltage_setpoint;
  logic clear_req;
  assign clear_req = reg_wr && reg_addr == OFS_CTRL
    && reg_wdata[CTRL_CLEAR_BIT];
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      enable_q <= 1'b0;
      boost_phase_duration <= '0;
      peak_phase_duration <= '0;
      energy_return_duration <= '0;
      peak_current_target <= '0;
      hold_current_target <= '0;
      idle_voltage_setpoint <= '0;
      inject_voltage_setpoint <= '0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        OFS_CTRL: enable_q <= reg_wdata[CTRL_ENABLE_BIT];
        OFS_BOOST_DUR: boost_phase_duration <= reg_wdata[TW-1:0];
        OFS_PEAK_DUR: peak_phase_duration <= reg_wdata[TW-1:0];
        OFS_RETURN_DUR: energy_return_duration <= reg_wdata[TW-1:0];
        OFS_PEAK_CUR: peak_current_target <= reg_wdata[7:0];
        OFS_HOLD_CUR: hold_current_target <= reg_wdata[7:0];
        OFS_IDLE_V: idle_voltage_setpoint <= reg_wdata[7:0];
        OFS_INJECT_V: inject_voltage_setpoint <= reg_wdata[7:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Channel arbitration
  // ---------------------------------------------------------------
  phase_t phase_q;
  logic [NCH-1:0] served_q, start_req, grant;
  logic [1:0] chan_q, grant_idx;
  logic cmd_active, start;
  assign start_req = inject_cmd & ~served_q;
  always_comb
  begin
    grant = '0;
    grant_idx = 2'h0;
    for (int i = NCH - 1; i >= 0; i--)
    begin
      if (start_req[i])
      begin
        grant = '0;
        grant[i] = 1'b1;
        grant_idx = 2'(i);
      end
    end
  end
  // New event only from idle, one channel at a time [RULE4]
  assign start = phase_q == PH_IDLE && enable_q && !critical_fault
    && |start_req;
  assign cmd_active = inject_cmd[chan_q];

  // Each channel starts once per command level, rearmed when its command drops
  always_ff @(posedge clock)
  begin
    if (srst)
      served_q <= '0;
    else
      served_q <= (served_q | (start ? grant : '0)) & inject_cmd; // [RULE17]
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      chan_q <= 2'h0;
    else if (start)
      chan_q <= grant_idx;
  end

  // ---------------------------------------------------------------
  // Phase timers
  // ---------------------------------------------------------------
  logic [TW-1:0] boost_t_q, peak_t_q, ret_t_q;
  logic boost_end, peak_end, ret_end;
  assign boost_end = boost_t_q <= TW'(1)
    || cur_q >= peak_current_target; // [RULE6]
  assign peak_end = peak_t_q <= TW'(1);
  assign ret_end = ret_t_q <= TW'(1);
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      boost_t_q <= '0;
      peak_t_q <= '0;
      ret_t_q <= '0;
    end
    else if (start)
    begin
      boost_t_q <= boost_phase_duration; // [RULE18]
      peak_t_q <= peak_phase_duration;
      ret_t_q <= energy_return_duration;
    end
    else
    begin
      if (phase_q == PH_BOOST && boost_t_q != '0)
        boost_t_q <= boost_t_q - TW'(1);
      // Peak time runs from injection start, boost included [RULE7]
      if ((phase_q == PH_BOOST || phase_q == PH_PEAK) && peak_t_q != '0)
        peak_t_q <= peak_t_q - TW'(1);
      if (phase_q == PH_RETURN && ret_t_q != '0)
        ret_t_q <= ret_t_q - TW'(1);
    end
  end

  // ---------------------------------------------------------------
  // Open load detection
  // ---------------------------------------------------------------
  logic seen_current_q;
  always_ff @(posedge clock)
  begin
    if (srst || start)
      seen_current_q <= 1'b0;
    else if (phase_q == PH_BOOST && cur_q > OPEN_LOAD_CODE)
      seen_current_q <= 1'b1;
  end
  logic open_now;
  assign open_now = phase_q == PH_BOOST && cmd_active && boost_end
    && !seen_current_q && !(cur_q > OPEN_LOAD_CODE); // [RULE15]

  // Refreshed at each boost end of that channel [RULE16]
  logic [NCH-1:0] open_q;
  always_ff @(posedge clock)
  begin
    if (srst)
      open_q <= '0;
    else if (phase_q == PH_BOOST && cmd_active && boost_end)
      open_q[chan_q] <= open_now;
  end
  assign open_load_fault = open_q;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  logic ret_zero;
  assign ret_zero = energy_return_duration == '0;
  always_ff @(posedge clock)
  begin
    if (srst || critical_fault)
      phase_q <= PH_IDLE; // [RULE12]
    else
    begin
      case (phase_q)
        PH_IDLE:
          if (start)
            phase_q <= PH_BOOST; // [RULE5]
        PH_BOOST:
          if (!cmd_active)
            phase_q <= ret_zero ? PH_IDLE : PH_RETURN;
          else if (boost_end)
          begin
            if (open_now)
              phase_q <= PH_IDLE; // [RULE15]
            else if (peak_end)
              phase_q <= PH_HOLD;
            else
              phase_q <= PH_PEAK; // [RULE7]
          end
        PH_PEAK:
          if (!cmd_active)
            phase_q <= ret_zero ? PH_IDLE : PH_RETURN; // [RULE10]
          else if (peak_end)
            phase_q <= PH_HOLD; // [RULE9]
        PH_HOLD:
          if (!cmd_active)
            phase_q <= ret_zero ? PH_IDLE : PH_RETURN; // [RULE10]
        PH_RETURN:
          if (ret_end)
            phase_q <= PH_IDLE;
        default:
          phase_q <= PH_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Battery chopping
  // ---------------------------------------------------------------
  logic chop_phase, below;
  logic [7:0] target;
  logic [CHOP_W-1:0] dly_q;
  logic batt_q;
  assign chop_phase = phase_q == PH_PEAK || phase_q == PH_HOLD;
  assign target = phase_q == PH_HOLD ? hold_current_target
    : peak_current_target; // [RULE9]
  assign below = cur_q < target;
  always_ff @(posedge clock)
  begin
    if (srst || !chop_phase || !below || batt_q || critical_fault)
      dly_q <= '0;
    else if (dly_q == '0)
      dly_q <= CHOP_W'(CHOP_CYC); // [RULE8]
    else
      dly_q <= dly_q - CHOP_W'(1);
  end
  always_ff @(posedge clock)
  begin
    if (srst || !chop_phase || !below || critical_fault)
      batt_q <= 1'b0;
    else if (dly_q == CHOP_W'(1))
      batt_q <= 1'b1; // [RULE8]
  end

  // ---------------------------------------------------------------
  // Faults
  // ---------------------------------------------------------------
  logic short_fault, boost_driver_fault, battery_driver_fault;
  logic short_hit;
  assign short_hit = ovc_q || cur_q >= SHORT_CODE;
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      short_fault <= 1'b0;
      boost_driver_fault <= 1'b0;
      battery_driver_fault <= 1'b0;
    end
    else
    begin
      // Set wins over a clear in the same cycle
      short_fault <= short_hit || (short_fault && !clear_req); // [RULE13]
      boost_driver_fault <= (gnd_q && phase_q == PH_BOOST)
        || (boost_driver_fault && !clear_req); // [RULE14]
      battery_driver_fault <= (gnd_q && chop_phase)
        || (battery_driver_fault && !clear_req); // [RULE14]
    end
  end
  assign critical_fault = short_fault || boost_driver_fault
    || battery_driver_fault; // [RULE12]

  // ---------------------------------------------------------------
  // Boost supply control
  // ---------------------------------------------------------------
  logic ext_hv, inj_busy, charge_q;
  logic [7:0] setpoint;
  assign ext_hv = ext_q > EXT_HV_CODE; // [RULE3]
  assign inj_busy = phase_q != PH_IDLE;
  assign setpoint = inj_busy ? inject_voltage_setpoint
    : idle_voltage_setpoint; // [RULE1]
  always_ff @(posedge clock)
  begin
    if (srst)
      charge_q <= 1'b0;
    else
      charge_q <= enable_q && !critical_fault && !ext_hv
        && hv_q < setpoint; // [RULE2] [RULE3] [RULE12]
  end
  assign boost_charge_en = charge_q;

  // ---------------------------------------------------------------
  // Drive outputs
  // ---------------------------------------------------------------
  assign hv_drive = phase_q == PH_BOOST; // [RULE5]
  assign battery_drive = batt_q;
  assign energy_return = phase_q == PH_RETURN; // [RULE10]
  always_ff @(posedge clock)
  begin
    if (srst)
      channel_select <= '0;
    else if (start)
      channel_select <= grant;
    else if (phase_q == PH_IDLE)
      channel_select <= '0;
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] status;
  always_comb
  begin
    status = '0;
    status[ST_OPEN_LSB +: NCH] = open_q;
    status[ST_SHORT_BIT] = short_fault;
    status[ST_BOOST_DRV_BIT] = boost_driver_fault;
    status[ST_BATT_DRV_BIT] = battery_driver_fault;
    status[ST_STATE_LSB +: 3] = phase_q;
    status[ST_CHAN_LSB +: 2] = chan_q;
    status[ST_CHARGE_BIT] = charge_q;
    status[ST_EXT_HV_BIT] = ext_hv;
  end
  always_ff @(posedge clock)
  begin
    if (srst)
      reg_rdata <= '0;
    else if (reg_rd)
    begin
      case (reg_addr)
        OFS_CTRL: reg_rdata <= DATA_W'(enable_q);
        OFS_BOOST_DUR: reg_rdata <= DATA_W'(boost_phase_duration);
        OFS_PEAK_DUR: reg_rdata <= DATA_W'(peak_phase_duration);
        OFS_RETURN_DUR: reg_rdata <= DATA_W'(energy_return_duration);
        OFS_PEAK_CUR: reg_rdata <= DATA_W'(peak_current_target);
        OFS_HOLD_CUR: reg_rdata <= DATA_W'(hold_current_target);
        OFS_IDLE_V: reg_rdata <= DATA_W'(idle_voltage_setpoint);
        OFS_INJECT_V: reg_rdata <= DATA_W'(inject_voltage_setpoint);
        OFS_STATUS: reg_rdata <= status;
        default: reg_rdata <= '0;
      endcase
    end
    else
      reg_rdata <= '0;
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_setpoint;
    @(posedge clock) disable iff (srst)
    (inj_busy && hv_q >= inject_voltage_setpoint) |=> !charge_q;
  endproperty
  a_setpoint: assert property (p_setpoint) // [RULE1]
    else $error("charging above inject setpoint");
  property p_resume;
    @(posedge clock) disable iff (srst)
    (phase_q == PH_IDLE && enable_q && !critical_fault && !ext_hv
      && hv_q < idle_voltage_setpoint) |=> charge_q;
  endproperty
  a_resume: assert property (p_resume) // [RULE2]
    else $error("idle charge did not resume");
  property p_ext;
    @(posedge clock) disable iff (srst)
    ext_hv |=> !charge_q;
  endproperty
  a_ext: assert property (p_ext) // [RULE3]
    else $error("boost runs with external supply");
  property p_onehot;
    @(posedge clock) disable iff (srst)
    $onehot0(channel_select) && !(hv_drive && battery_drive);
  endproperty
  a_onehot: assert property (p_onehot) // [RULE4]
    else $error("overlapping channel drive");
  property p_hv_once;
    @(posedge clock) disable iff (srst)
    $rose(hv_drive) |-> $past(phase_q) == PH_IDLE;
  endproperty
  a_hv_once: assert property (p_hv_once) // [RULE5]
    else $error("high voltage reapplied in one event");
  property p_chop;
    @(posedge clock) disable iff (srst)
    $rose(batt_q) |-> $past(dly_q) == CHOP_W'(1);
  endproperty
  a_chop: assert property (p_chop) // [RULE8]
    else $error("battery pulse without chop delay");
  property p_latch;
    @(posedge clock) disable iff (srst)
    (short_fault && !clear_req) |=> short_fault && phase_q == PH_IDLE;
  endproperty
  a_latch: assert property (p_latch) // [RULE12]
    else $error("short fault lost or operation continued");
  property p_open;
    @(posedge clock) disable iff (srst)
    open_now |=> phase_q == PH_IDLE && open_q[$past(chan_q)];
  endproperty
  a_open: assert property (p_open) // [RULE15]
    else $error("open load not reported");
endmodule

// >>> verification/solenoid_model.sv
// Solenoid and high-voltage reservoir model
`timescale 1ns/1ps
module solenoid_model (
  input wire logic clock,
  input wire logic srst,
  input wire logic hv_drive,
  input wire logic battery_drive,
  input wire logic energy_return,
  input wire logic boost_charge_en,
  input wire logic open_load,
  output logic [7:0] cur_sense,
  output logic [7:0] hv_sense
);
  logic [7:0] cur_q;
  logic [7:0] hv_q;
  // ---------------------------------------------------------------
  // Coil current: fast rise on boost, slow on battery
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst || open_load)
      cur_q <= 8'h00;
    else if (hv_drive)
      cur_q <= (cur_q < 8'h6A) ? cur_q + 8'h04 : 8'h6E;
    else if (battery_drive)
      cur_q <= (cur_q < 8'h6E) ? cur_q + 8'h01 : 8'h6E;
    else if (energy_return)
      cur_q <= (cur_q > 8'h08) ? cur_q - 8'h08 : 8'h00;
    else if (cur_q != 8'h00)
      cur_q <= cur_q - 8'h01;
  end
  // ---------------------------------------------------------------
  // Reservoir: charges when enabled, drained by boost drive
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
      hv_q <= 8'h00;
    else if (boost_charge_en && hv_q < 8'hFA)
      hv_q <= hv_q + 8'h01;
    else if (hv_drive && hv_q != 8'h00)
      hv_q <= hv_q - 8'h01;
  end
  assign cur_sense = cur_q;
  assign hv_sense = hv_q;
endmodule

// >>> verification/tb.sv
// Self-checking testbench of the injector sequencer
`timescale 1ns/1ps
module tb;
  import inj_seq_pkg::*;
  localparam int BOOST = 10;
  localparam int PEAK = 2000;
  localparam int RET = 20;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [2:0] inject_cmd = 3'h0;
  logic [7:0] cur_sense;
  logic [7:0] hv_sense;
  logic [7:0] ext_hv_sense = 8'h00;
  logic overcurrent_alarm = 1'b0;
  logic high_terminal_gnd_short = 1'b0;
  logic open_load = 1'b0;
  logic [2:0] channel_select;
  logic hv_drive;
  logic battery_drive;
  logic energy_return;
  logic boost_charge_en;
  logic critical_fault;
  logic [2:0] open_load_fault;
  int fail_count = 0;
  int checks = 0;
  always #50 clock = ~clock;
  injector_current_profile_sequencer #(.TW(16), .NCH(3)) i_dut (
    .clock(clock), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .inject_cmd(inject_cmd),
    .cur_sense(cur_sense), .hv_sense(hv_sense),
    .ext_hv_sense(ext_hv_sense), .overcurrent_alarm(overcurrent_alarm),
    .high_terminal_gnd_short(high_terminal_gnd_short),
    .channel_select(channel_select), .hv_drive(hv_drive),
    .battery_drive(battery_drive), .energy_return(energy_return),
    .boost_charge_en(boost_charge_en), .critical_fault(critical_fault),
    .open_load_fault(open_load_fault));
  solenoid_model i_model (
    .clock(clock), .srst(srst), .hv_drive(hv_drive),
    .battery_drive(battery_drive), .energy_return(energy_return),
    .boost_charge_en(boost_charge_en), .open_load(open_load),
    .cur_sense(cur_sense), .hv_sense(hv_sense));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input bit ok, input string msg);
    checks++;
    if (!ok)
    begin
      fail_count++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic cmd(input int ch, input logic v);
    @(posedge clock);
    inject_cmd[ch] <= v;
    #1;
  endtask
  function automatic bit cond(input int s);
    case (s)
      0: return hv_drive === 1'b1;
      1: return hv_drive === 1'b0;
      2: return energy_return === 1'b1;
      3: return energy_return === 1'b0;
      4: return battery_drive === 1'b1;
      5: return channel_select === 3'h0;
      6: return critical_fault === 1'b1;
      8: return boost_charge_en === 1'b0;
      default: return boost_charge_en === 1'b1;
    endcase
  endfunction
  task automatic wait_for(input int s, input int lim, output int n);
    n = 0;
    while (!cond(s))
    begin
      if (n >= lim)
      begin
        fail_count++;
        $display("MISMATCH %0t wait %0d ran out", $time, s);
        summarize();
      end
      step(1);
      n++;
    end
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_setup();
    logic [31:0] d;
    int n;
    chk(channel_select === 3'h0 && critical_fault === 1'b0, "reset");
    rd(8'hFC, d);
    chk(d === 32'h0, "unmapped read");
    wr(OFS_BOOST_DUR, BOOST);
    wr(OFS_PEAK_DUR, PEAK);
    wr(OFS_RETURN_DUR, RET);
    wr(OFS_PEAK_CUR, 32'h64);
    wr(OFS_HOLD_CUR, 32'h1E);
    wr(OFS_IDLE_V, 32'h14);
    wr(OFS_INJECT_V, 32'h0A);
    wr(OFS_CTRL, 32'h1);
    wait_for(7, 10, n);
    wait_for(8, 100, n);
    wait_for(1, 0, n);
    step(5);
    chk(boost_charge_en === 1'b0 && hv_sense >= 8'h14, "idle aim");
    $display("end t_setup");
  endtask
  task automatic t_inject();
    logic [31:0] d;
    int n;
    int bad;
    cmd(0, 1'b1);
    wait_for(0, 5, n);
    chk(channel_select === 3'h1, "select");
    wait_for(1, BOOST + 2, n);
    chk(n == BOOST, "boost length");
    wait_for(4, 520, n);
    chk(n >= 500 && n <= 505, "chop delay");
    chk(boost_charge_en === 1'b0, "inject aim");
    rd(OFS_STATUS, d);
    chk(d[8:6] === PH_PEAK, "peak phase");
    bad = 0;
    for (int i = 0; i < 1600; i++)
    begin
      step(1);
      if (hv_drive !== 1'b0)
        bad++;
    end
    chk(bad == 0, "boost reused");
    rd(OFS_STATUS, d);
    chk(d[8:6] === PH_HOLD, "hold phase");
    cmd(0, 1'b0);
    wait_for(2, 3, n);
    wait_for(3, RET + 2, n);
    chk(n == RET, "return length");
    wait_for(5, 3, n);
    wait_for(7, 10, n);
    chk(boost_charge_en === 1'b1, "charge resumes");
    $display("end t_inject");
  endtask
  task automatic t_early();
    int n;
    wr(OFS_BOOST_DUR, 32'h28);
    wr(OFS_PEAK_CUR, 32'h14);
    cmd(1, 1'b1);
    wait_for(0, 5, n);
    wait_for(1, 45, n);
    chk(n >= 4 && n < 20, "current ends boost");
    cmd(1, 1'b0);
    wait_for(5, 50, n);
    wr(OFS_BOOST_DUR, BOOST);
    wr(OFS_PEAK_CUR, 32'h64);
    $display("end t_early");
  endtask
  task automatic t_overlap();
    int n;
    int bad;
    @(posedge clock);
    inject_cmd <= 3'h3;
    wait_for(0, 5, n);
    chk(channel_select === 3'h1, "lowest first");
    bad = 0;
    for (int i = 0; i < 100; i++)
    begin
      step(1);
      if (channel_select !== 3'h1)
        bad++;
    end
    cmd(0, 1'b0);
    wait_for(2, 3, n);
    wait_for(3, RET + 2, n);
    chk(channel_select === 3'h1 && hv_drive === 1'b0, "gap");
    wait_for(0, 5, n);
    chk(bad == 0 && channel_select === 3'h2, "no overlap");
    cmd(1, 1'b0);
    wait_for(5, 60, n);
    $display("end t_overlap");
  endtask
  task automatic t_open();
    int n;
    open_load <= 1'b1;
    cmd(2, 1'b1);
    wait_for(0, 5, n);
    wait_for(1, BOOST + 2, n);
    step(3);
    chk(open_load_fault[2] === 1'b1, "open flagged");
    chk(channel_select === 3'h0, "pulse ended");
    chk(energy_return === 1'b0, "no return");
    cmd(2, 1'b0);
    open_load <= 1'b0;
    cmd(2, 1'b1);
    wait_for(0, 5, n);
    chk(critical_fault === 1'b0, "noncritical");
    wait_for(1, BOOST + 2, n);
    step(3);
    chk(open_load_fault[2] === 1'b0, "open cleared");
    cmd(2, 1'b0);
    wait_for(5, 60, n);
    $display("end t_open");
  endtask
  task automatic t_faults();
    logic [31:0] d;
    int n;
    for (int k = 0; k < 3; k++)
    begin
      cmd(0, 1'b1);
      wait_for(0, 5, n);
      if (k == 2)
        wait_for(1, BOOST + 2, n);
      if (k == 2)
        step(20);
      @(posedge clock);
      overcurrent_alarm <= (k == 0);
      high_terminal_gnd_short <= (k != 0);
      wait_for(6, 6, n);
      step(2);
      chk(hv_drive === 1'b0 && battery_drive === 1'b0, "drive off");
      chk(boost_charge_en === 1'b0, "charge off");
      rd(OFS_STATUS, d);
      chk(d[ST_SHORT_BIT + k] === 1'b1, "fault kind");
      overcurrent_alarm <= 1'b0;
      high_terminal_gnd_short <= 1'b0;
      cmd(0, 1'b0);
      step(5);
      cmd(0, 1'b1);
      step(20);
      chk(channel_select === 3'h0, "held off");
      cmd(0, 1'b0);
      wr(OFS_CTRL, 32'h3);
      step(2);
      chk(critical_fault === 1'b0, "cleared");
      step(100);
      wait_for(5, 60, n);
    end
    $display("end t_faults");
  endtask
  task automatic t_ext();
    logic [31:0] d;
    wr(OFS_IDLE_V, 32'hC8);
    @(posedge clock);
    ext_hv_sense <= 8'h06;
    step(6);
    chk(boost_charge_en === 1'b1, "at threshold");
    @(posedge clock);
    ext_hv_sense <= 8'h07;
    step(6);
    chk(boost_charge_en === 1'b0, "external stops boost");
    rd(OFS_STATUS, d);
    chk(d[ST_EXT_HV_BIT] === 1'b1, "external seen");
    step(1);
    chk(reg_rdata === 32'h0, "read data stands one cycle");
    @(posedge clock);
    ext_hv_sense <= 8'h00;
    $display("end t_ext");
  endtask
  initial
  begin
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    step(1);
    t_setup();
    t_inject();
    t_early();
    t_overlap();
    t_open();
    t_faults();
    t_ext();
    summarize();
  end
endmodule
